// ---- src/fwsr_bus_cycle.sv ----
// Single flash bus cycle engine: one read or one write per request
`default_nettype none
`include "fwsr_params.svh"
module fwsr_bus_cycle (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        go,
    input  wire logic        is_write,
    input  wire logic [16:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic [7:0]  dq_in,
    output logic             done,
    output logic [7:0]       rdata,
    output logic [16:0]      flash_addr,
    output logic [7:0]       dq_out,
    output logic             dq_oe,
    output logic             ce_n,
    output logic             we_n,
    output logic             oe_n
);
    import fwsr_pkg::*;

    typedef enum logic [1:0] {BC_IDLE, BC_ACT, BC_GAP} fwsr_bc_st_t;
    typedef struct packed {
        fwsr_bc_st_t st;
        logic [3:0]  cnt;
        logic        wr;
        logic        done;
        logic [7:0]  rdata;
        logic [16:0] addr;
        logic [7:0]  dout;
        logic        oe_drv;
        logic        ce_n;
        logic        we_n;
        logic        oe_n;
        logic [7:0]  sy1;
        logic [7:0]  sy2;
    } fwsr_bc_t;

    fwsr_bc_t s_r, s_nxt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        s_nxt.sy1  = dq_in;
        s_nxt.sy2  = s_r.sy1;
        case (s_r.st)
            BC_IDLE: begin
                if (go) begin
                    s_nxt.st     = BC_ACT;
                    s_nxt.wr     = is_write;
                    s_nxt.addr   = addr;
                    s_nxt.dout   = wdata;
                    s_nxt.oe_drv = is_write;
                    s_nxt.ce_n   = 1'b0;
                    s_nxt.we_n   = ~is_write;
                    s_nxt.oe_n   = is_write;
                    // Two extra cycles cover the input synchroniser
                    s_nxt.cnt    = is_write ? 4'(`FWSR_WE_CYC)
                                            : 4'(`FWSR_ACCESS_CYC + 2);
                end
            end
            BC_ACT: begin
                if (s_r.cnt > 4'h1) begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end else begin
                    // Deasserting CE ends the cycle and advances toggle
                    s_nxt.st    = BC_GAP;
                    s_nxt.ce_n  = 1'b1;
                    s_nxt.we_n  = 1'b1;
                    s_nxt.oe_n  = 1'b1;
                    s_nxt.rdata = s_r.sy2;
                    s_nxt.cnt   = 4'(`FWSR_GAP_CYC);
                end
            end
            BC_GAP: begin
                s_nxt.oe_drv = 1'b0;
                if (s_r.cnt > 4'h1) begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end else begin
                    s_nxt.st   = BC_IDLE;
                    s_nxt.done = 1'b1;
                end
            end
            default: s_nxt.st = BC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r      <= '0;
            s_r.st   <= BC_IDLE;
            s_r.ce_n <= 1'b1;
            s_r.we_n <= 1'b1;
            s_r.oe_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done       = s_r.done;
    assign rdata      = s_r.rdata;
    assign flash_addr = s_r.addr;
    assign dq_out     = s_r.dout;
    assign dq_oe      = s_r.oe_drv;
    assign ce_n       = s_r.ce_n;
    assign we_n       = s_r.we_n;
    assign oe_n       = s_r.oe_n;
endmodule
`default_nettype wire

// ---- src/fwsr_params.svh ----
// Constants for the flash write status polling controller
`ifndef FWSR_PARAMS_SVH
`define FWSR_PARAMS_SVH

// ----------------------------------------------------------------
// Status bit positions in the data byte
// ----------------------------------------------------------------
`define FWSR_POLL_BIT        3'd7
`define FWSR_TOGGLE_BIT      3'd6
`define FWSR_TIMEOUT_BIT     3'd5
`define FWSR_WINDOW_BIT      3'd3

// ----------------------------------------------------------------
// Command values
// ----------------------------------------------------------------
`define FWSR_CMD_RESET       8'hF0
`define FWSR_RESET_ADDR      17'h00000

// ----------------------------------------------------------------
// Bus cycle timing in clocks (40 MHz)
// ----------------------------------------------------------------
`define FWSR_CLK_NS          25
`define FWSR_ACCESS_NS       120
`define FWSR_ACCESS_CYC ((`FWSR_ACCESS_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_WE_NS           50
`define FWSR_WE_CYC     ((`FWSR_WE_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_GAP_NS          50
`define FWSR_GAP_CYC    ((`FWSR_GAP_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)

`endif

// ---- src/fwsr_pkg.sv ----
// Types for the flash write status polling controller
`default_nettype none
package fwsr_pkg;
    typedef enum logic [1:0] {
        FWSR_MODE_TOGGLE,
        FWSR_MODE_POLARITY,
        FWSR_MODE_RESET
    } fwsr_mode_t;

    typedef enum logic [1:0] {
        FWSR_RES_NONE,
        FWSR_RES_DONE,
        FWSR_RES_FAIL
    } fwsr_result_t;
endpackage
`default_nettype wire

// ---- src/fwsr_poller.sv ----
// Host controller polling a parallel flash for write operation status
//
// Notes on behaviour
// - Program polling reads the programmed address.
// - Erase polling reads inside a selected sector.
// - After poll flips, take data next read.
// - Two reads, unchanged busy bit means done.
// - Toggling with timeout set: recheck, fail if still toggling.
// - Resumed polling restarts from the first step.
// - After timeout failure issue the reset command.
// - Recheck poll bit after seeing timeout set.
// - Reset is one write of F0 anywhere.
`default_nettype none
`include "fwsr_params.svh"
module fwsr_poller (
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire logic                 start,
    input  wire fwsr_pkg::fwsr_mode_t mode,
    input  wire logic [16:0]          status_valid_address,
    input  wire logic [7:0]           expect_data,
    input  wire logic [7:0]           dq_in,
    output logic                      busy,
    output logic                      result_valid,
    output fwsr_pkg::fwsr_result_t    result,
    output logic [7:0]                final_data,
    output logic                      erase_window_bit,
    output logic [16:0]               flash_addr,
    output logic [7:0]                dq_out,
    output logic                      dq_oe,
    output logic                      ce_n,
    output logic                      we_n,
    output logic                      oe_n
);
    import fwsr_pkg::*;

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RD_FIRST,
        ST_RD_SECOND,
        ST_RD_RECHECK,
        ST_RD_FINAL,
        ST_WR_RESET,
        ST_REPORT
    } fwsr_st_t;

    typedef struct packed {
        fwsr_st_t     st;
        fwsr_mode_t   mode;
        logic [16:0]  addr;
        logic [7:0]   exp_byte;
        logic         tog_prev;
        logic         tout_seen;
        logic         go;
        logic         is_wr;
        logic         waiting;
        logic         busy;
        logic         res_v;
        fwsr_result_t res;
        logic [7:0]   data;
        logic         window;
    } fwsr_state_t;

    fwsr_state_t  s_r, s_nxt;
    logic         bc_done;
    logic [7:0]   bc_rdata;

    // Poll bit reached expected value (program: data bit, erase: 1)
    function automatic logic poll_true(input logic [7:0] d,
                                       input logic [7:0] e);
        poll_true = (d[`FWSR_POLL_BIT] == e[`FWSR_POLL_BIT]);
    endfunction

    function automatic logic bit_of(input logic [7:0] d,
                                    input logic [2:0] pos);
        bit_of = d[pos];
    endfunction

    // ------------------------------------------------------------
    // Bus cycle engine
    // ------------------------------------------------------------
    fwsr_bus_cycle u_cycle (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .go         (s_r.go),
        .is_write   (s_r.is_wr),
        .addr       (s_r.is_wr ? `FWSR_RESET_ADDR : s_r.addr),
        .wdata      (`FWSR_CMD_RESET),
        .dq_in      (dq_in),
        .done       (bc_done),
        .rdata      (bc_rdata),
        .flash_addr (flash_addr),
        .dq_out     (dq_out),
        .dq_oe      (dq_oe),
        .ce_n       (ce_n),
        .we_n       (we_n),
        .oe_n       (oe_n)
    );

    // ------------------------------------------------------------
    // Polling algorithms
    // ------------------------------------------------------------
    always_comb begin
        s_nxt       = s_r;
        s_nxt.go    = 1'b0;
        s_nxt.res_v = 1'b0;
        case (s_r.st)
            ST_IDLE: begin
                // Start is only legal after the final write strobe
                if (start) begin
                    s_nxt.mode      = mode;
                    s_nxt.addr      = status_valid_address;
                    // Erase completes toward all ones
                    s_nxt.exp_byte  = (mode == FWSR_MODE_POLARITY) ?
                                      expect_data : 8'hFF;
                    s_nxt.tout_seen = 1'b0;
                    s_nxt.busy      = 1'b1;
                    s_nxt.waiting   = 1'b0;
                    if (mode == FWSR_MODE_RESET) begin
                        s_nxt.st = ST_WR_RESET;
                    end else begin
                        // Every new polling session starts at the first read
                        s_nxt.st = ST_RD_FIRST;
                    end
                end
            end
            ST_RD_FIRST, ST_RD_SECOND, ST_RD_RECHECK, ST_RD_FINAL,
            ST_WR_RESET: begin
                if (!s_r.waiting) begin
                    s_nxt.go      = 1'b1;
                    s_nxt.is_wr   = (s_r.st == ST_WR_RESET);
                    s_nxt.waiting = 1'b1;
                end else if (bc_done) begin
                    s_nxt.waiting = 1'b0;
                    // A write cycle returns no status byte
                    if (s_r.st != ST_WR_RESET) begin
                        s_nxt.window = bit_of(bc_rdata, `FWSR_WINDOW_BIT);
                    end
                    s_nxt.tog_prev = bit_of(bc_rdata, `FWSR_TOGGLE_BIT);
                    case (s_r.st)
                        ST_RD_FIRST: begin
                            if (s_r.mode == FWSR_MODE_TOGGLE) begin
                                s_nxt.st = ST_RD_SECOND;
                            end else if (poll_true(bc_rdata,
                                                   s_r.exp_byte)) begin
                                // Low bits may lag the poll bit
                                s_nxt.st = ST_RD_FINAL;
                            end else if (bit_of(bc_rdata,
                                                `FWSR_TIMEOUT_BIT)) begin
                                s_nxt.st = ST_RD_RECHECK;
                            end
                        end
                        ST_RD_SECOND: begin
                            // Busy bit inverts on every read while running
                            if (bit_of(bc_rdata, `FWSR_TOGGLE_BIT) ==
                                s_r.tog_prev) begin
                                s_nxt.st = ST_RD_FINAL;
                            end else if (bit_of(bc_rdata,
                                                `FWSR_TIMEOUT_BIT)) begin
                                s_nxt.st = ST_RD_RECHECK;
                            end
                            // Otherwise keep comparing pairs
                        end
                        ST_RD_RECHECK: begin
                            if (s_r.mode == FWSR_MODE_TOGGLE) begin
                                if (bit_of(bc_rdata, `FWSR_TOGGLE_BIT) ==
                                    s_r.tog_prev) begin
                                    s_nxt.st = ST_RD_FINAL;
                                end else begin
                                    s_nxt.tout_seen = 1'b1;
                                    s_nxt.st = ST_WR_RESET;
                                end
                            end else if (poll_true(bc_rdata,
                                                   s_r.exp_byte)) begin
                                s_nxt.st = ST_RD_FINAL;
                            end else begin
                                // Covers illegal 0-to-1 program too
                                s_nxt.tout_seen = 1'b1;
                                s_nxt.st = ST_WR_RESET;
                            end
                        end
                        ST_RD_FINAL: begin
                            s_nxt.data = bc_rdata;
                            s_nxt.res  = FWSR_RES_DONE;
                            s_nxt.st   = ST_REPORT;
                        end
                        default: begin
                            // Reset write returns flash to array read
                            s_nxt.res = s_r.tout_seen ? FWSR_RES_FAIL
                                                      : FWSR_RES_DONE;
                            s_nxt.st  = ST_REPORT;
                        end
                    endcase
                end
            end
            ST_REPORT: begin
                s_nxt.res_v = 1'b1;
                s_nxt.busy  = 1'b0;
                s_nxt.st    = ST_IDLE;
            end
            default: s_nxt.st = ST_IDLE;
        endcase
    end

    // Protected-sector busy windows and suspended sectors need no
    // special path: polling simply waits them out.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r      <= '0;
            s_r.st   <= ST_IDLE;
            s_r.mode <= FWSR_MODE_TOGGLE;
            s_r.res  <= FWSR_RES_NONE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy             = s_r.busy;
    assign result_valid     = s_r.res_v;
    assign result           = s_r.res;
    assign final_data       = s_r.data;
    assign erase_window_bit = s_r.window;
endmodule
`default_nettype wire

// ---- tb/fwsr_flash_model.sv ----
// Behavioural flash device answering status reads
`default_nettype none
module fwsr_flash_model (
    input  wire logic        sys_clk,
    input  wire logic        arm,
    input  wire logic        is_erase,
    input  wire logic [8:0]  reads,
    input  wire logic        fail,
    input  wire logic [7:0]  data,
    input  wire logic [16:0] va,
    input  wire logic [16:0] flash_addr,
    input  wire logic [7:0]  dq_out,
    input  wire logic        dq_oe,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    output logic [7:0]       dq,
    output logic             got_rst = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       act  = 1'b0;
    logic       er   = 1'b0;
    logic       tog  = 1'b0;
    logic       to   = 1'b0;
    logic       rd_q = 1'b0;
    logic       we_q = 1'b1;
    logic [8:0] rem  = 9'h000;
    logic [7:0] pd   = 8'hFF;
    logic [7:0] last = 8'h00;
    logic [7:0] st;
    logic       rd;
    assign rd = !ce_n && !oe_n;
    // Released bus never repeats the last byte
    assign dq = rd ? st : ~last;
    always_comb begin
        st = pd;
        if (act) begin
            st[7] = er ? 1'b0 : ~pd[7];
            if (flash_addr != va)
                st[7] = ~st[7];
            st[6] = tog;
            st[5] = to;
            st[3] = er;
        end
    end
    always @(posedge sys_clk) begin
        rd_q <= rd;
        we_q <= we_n;
        if (rd)
            last <= st;
        if (arm) begin
            act     <= 1'b1;
            er      <= is_erase;
            rem     <= reads;
            pd      <= data;
            to      <= 1'b0;
            got_rst <= 1'b0;
        end else if (rd_q && !rd && act) begin
            tog <= ~tog;
            if (rem != 9'h000)
                rem <= rem - 9'h001;
            else if (fail)
                to <= 1'b1;
            else
                act <= 1'b0;
        end
        if (we_q && !we_n && dq_oe && dq_out == 8'hF0) begin
            act     <= 1'b0;
            got_rst <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/fwsr_poller_checker.sv ----
// Port assertions for the flash status poller
`default_nettype none
`include "fwsr_params.svh"
module fwsr_poller_checker
    import fwsr_pkg::*;
(
    input wire logic                   sys_clk,
    input wire logic                   reset_n,
    input wire logic                   start,
    input wire fwsr_pkg::fwsr_mode_t   mode,
    input wire logic [16:0]            status_valid_address,
    input wire logic                   busy,
    input wire logic                   result_valid,
    input wire fwsr_pkg::fwsr_result_t result,
    input wire logic [16:0]            flash_addr,
    input wire logic [7:0]             dq_out,
    input wire logic                   dq_oe,
    input wire logic                   ce_n,
    input wire logic                   we_n,
    input wire logic                   oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic [3:0] rd_cnt_r;
    logic       wrote_r;
    // Reads and writes seen since the last accepted start
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_cnt_r <= 4'h0;
            wrote_r  <= 1'b0;
        end else if (start && !busy) begin
            rd_cnt_r <= 4'h0;
            wrote_r  <= 1'b0;
        end else begin
            if ($rose(oe_n) && rd_cnt_r != 4'hF)
                rd_cnt_r <= rd_cnt_r + 4'h1;
            if (!we_n)
                wrote_r <= 1'b1;
        end
    end
    sequence wr_pulse;
        !we_n [*2] ##1 we_n;
    endsequence
    sequence rd_hold;
        (!oe_n && !ce_n) [*5];
    endsequence
    chk_read_addr: assert property (
        !ce_n && !oe_n |-> flash_addr == status_valid_address)
        else $error("status read away from the polled address");
    chk_reset_cmd: assert property (
        !we_n |-> oe_n && dq_oe && dq_out == `FWSR_CMD_RESET
            && flash_addr == `FWSR_RESET_ADDR)
        else $error("write is not the reset command");
    chk_write_pulse: assert property (
        $fell(we_n) |-> wr_pulse)
        else $error("write strobe shape wrong");
    chk_read_hold: assert property (
        $fell(oe_n) |-> rd_hold)
        else $error("read strobe released too early");
    chk_one_result: assert property (
        result_valid |=> !result_valid)
        else $error("result pulse longer than one cycle");
    chk_idle_quiet: assert property (
        !busy && !result_valid |-> oe_n)
        else $error("read strobe active while idle");
    chk_done_reads: assert property (
        result_valid && result == FWSR_RES_DONE && mode != FWSR_MODE_RESET
            |-> rd_cnt_r >= 4'h2)
        else $error("done reported after fewer than two reads");
    chk_fail_reset: assert property (
        result_valid && result == FWSR_RES_FAIL
            |-> rd_cnt_r >= 4'h2 ##[0:40] wrote_r)
        else $error("failure without recheck or reset command");
endmodule
bind fwsr_poller fwsr_poller_checker u_chk (.sys_clk(sys_clk),
    .reset_n(reset_n), .start(start), .mode(mode), .busy(busy),
    .status_valid_address(status_valid_address), .result(result),
    .result_valid(result_valid), .flash_addr(flash_addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n));
`default_nettype wire

// ---- tb/fwsr_poller_tb_top.sv ----
// Self-checking bench for the flash status poller
`default_nettype none
module fwsr_poller_tb_top
    import fwsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // About 2 us and 100 us of status reads
    localparam logic [8:0] PGM_PROT = 9'h006;
    localparam logic [8:0] ERS_PROT = 9'h14D;
    logic sys_clk = 1'b0, reset_n, start, arm, is_erase, fail;
    logic busy, result_valid, ewb, dq_oe, ce_n, we_n, oe_n, got_rst;
    logic [7:0] expect_data, dq_in, final_data, dq_out, mdata;
    logic [16:0] sva, flash_addr;
    logic [8:0] reads;
    logic [31:0] seed = 32'h0000C8F1;
    fwsr_mode_t mode;
    fwsr_result_t result;
    int n_fail = 0, n_tests = 0;
    always #12.5 sys_clk = ~sys_clk;
    fwsr_poller dut (.sys_clk(sys_clk), .reset_n(reset_n), .start(start),
        .mode(mode), .status_valid_address(sva), .expect_data(expect_data),
        .dq_in(dq_in), .busy(busy), .result_valid(result_valid),
        .result(result), .final_data(final_data), .erase_window_bit(ewb),
        .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
        .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n));
    fwsr_flash_model u_flash (.sys_clk(sys_clk), .arm(arm),
        .is_erase(is_erase), .reads(reads), .fail(fail), .data(mdata),
        .va(sva), .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
        .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .dq(dq_in),
        .got_rst(got_rst));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] exp_res(input logic f);
        return {6'h00, f ? FWSR_RES_FAIL : FWSR_RES_DONE};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic run(input fwsr_mode_t m, input logic er,
                       input logic [8:0] n, input logic f,
                       input logic [7:0] d);
        int k;
        k = 0;
        seed = xs(seed);
        @(negedge sys_clk);
        mode = m;
        is_erase = er;
        reads = n;
        fail = f;
        mdata = d;
        expect_data = d;
        sva = seed[16:0];
        arm = 1'b1;
        start = 1'b1;
        @(negedge sys_clk);
        arm = 1'b0;
        // Second start while busy must be ignored
        @(negedge sys_clk);
        start = 1'b0;
        check({7'h00, busy}, 8'h01);
        while (result_valid !== 1'b1 && k < 9000) begin
            @(negedge sys_clk);
            k++;
        end
        if (k == 9000) begin
            n_fail++;
            results();
        end else begin
            check({6'h00, result}, exp_res(f));
            if (!f && m != FWSR_MODE_RESET)
                check(final_data, d);
            if (m != FWSR_MODE_RESET)
                check({7'h00, ewb}, {7'h00, f ? er : d[3]});
            repeat (60) @(negedge sys_clk);
            check({7'h00, got_rst}, {7'h00, f || m == FWSR_MODE_RESET});
            $display("test done: mode %0d reads %0d fail %0d", m, n, f);
        end
    endtask
    initial begin
        {reset_n, start, arm, is_erase, fail} = 5'h00;
        {expect_data, mdata, sva, reads} = '0;
        mode = FWSR_MODE_TOGGLE;
        repeat (5) @(negedge sys_clk);
        reset_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            run(seed[0] ? FWSR_MODE_TOGGLE : FWSR_MODE_POLARITY, seed[1],
                {6'h00, seed[4:2]}, 1'b0, seed[1] ? 8'hFF : seed[15:8]);
        end
        run(FWSR_MODE_TOGGLE, 1'b0, 9'h000, 1'b0, 8'h5A);
        run(FWSR_MODE_TOGGLE, 1'b0, PGM_PROT, 1'b0, 8'h3C);
        run(FWSR_MODE_TOGGLE, 1'b1, ERS_PROT, 1'b0, 8'hC3);
        run(FWSR_MODE_TOGGLE, 1'b0, 9'h002, 1'b1, 8'h0F);
        run(FWSR_MODE_POLARITY, 1'b0, 9'h002, 1'b1, 8'h80);
        run(FWSR_MODE_POLARITY, 1'b1, 9'h001, 1'b1, 8'hFF);
        mode = FWSR_MODE_TOGGLE;
        reads = 9'h009;
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        repeat (20) @(negedge sys_clk);
        reset_n = 1'b0;
        @(negedge sys_clk);
        check({4'h0, busy, ce_n, oe_n, we_n}, 8'h07);
        reset_n = 1'b1;
        run(FWSR_MODE_POLARITY, 1'b0, 9'h003, 1'b0, 8'h11);
        run(FWSR_MODE_RESET, 1'b0, 9'h000, 1'b0, 8'h00);
        results();
    end
endmodule
`default_nettype wire
